// >>> crsu_pkg.sv
/*
 * crsu_pkg: constants and carriers for the card response and status unit.
 * assumes: included before crsu_core; no tool-specific features.
 */
package crsu_pkg;

    // ************************************************************
    // frame layout
    // ************************************************************
    localparam int FRAME_BITS = 48;
    localparam logic [5:0] IDX_ALL_ONES = 6'h3F;
    localparam logic [5:0] IDX_PUBLISH = 6'h03;
    localparam logic [5:0] IDX_IFCOND = 6'h08;
    localparam logic [6:0] OPCOND_TRAILER = 7'h7F;
    localparam logic [19:0] IFCOND_RESVD = 20'h00000;
    localparam logic [6:0] CRC7_POLY = 7'h09;

    // ************************************************************
    // voltage codes; only VOLT_HIGH is accepted
    // ************************************************************
    localparam logic [3:0] VOLT_HIGH = 4'h1;
    localparam logic [3:0] VOLT_LOW = 4'h2;

    // ************************************************************
    // status word bit positions
    // ************************************************************
    localparam int ST_RANGE = 31;
    localparam int ST_ADDR = 30;
    localparam int ST_BLKLEN = 29;
    localparam int ST_ERSEQ = 28;
    localparam int ST_ERSEL = 27;
    localparam int ST_PROT = 26;
    localparam int ST_LOCKED = 25;
    localparam int ST_LOCKFAIL = 24;
    localparam int ST_CRC = 23;
    localparam int ST_ILLEGAL = 22;
    localparam int ST_ECC = 21;
    localparam int ST_CTRL = 20;
    localparam int ST_GENERAL = 19;
    localparam int ST_SPECDATA = 16;
    localparam int ST_ERASESKIP = 15;
    localparam int ST_STATE_LO = 9;
    localparam int QUERY_SEL_BIT = 15;
    localparam logic [31:0] STATUS_RESET = 32'h00000000;
    // clear-by-read bits: 31,30,29,28,27,26,24,21,20,19,16,15
    localparam logic [31:0] CLEAR_ON_READ = 32'hFD398000;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef enum logic [1:0] {
        CRSU_KIND_STATUS,
        CRSU_KIND_OPCOND,
        CRSU_KIND_PUBLISH,
        CRSU_KIND_IFCOND
    } crsu_kind_e;

    typedef struct packed {
        logic argument_range_fault;
        logic address_fault;
        logic block_length_fault;
        logic erase_order_fault;
        logic erase_selection_fault;
        logic protected_write_fault;
        logic lock_fault;
        logic ecc_fault;
        logic controller_fault;
        logic general_fault;
        logic specific_data_write_fault;
        logic erase_skip;
    } crsu_events_s;

    typedef struct packed {
        crsu_kind_e kind;
        logic [5:0] index;
        logic [31:0] arg;
    } crsu_req_s;

endpackage

// >>> crsu_core.sv
/*
 * crsu_core: builds 48-bit response frames, keeps the card status word
 * and shifts frames out on the command line in the bus-clock domain.
 * assumes: clk_i system clock at 250 MHz; link_clk_i is the bus clock,
 * which runs while a frame is sent; events arrive on clk_i.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - operating-condition reply: 48 bits, register in 39:8, index and trailer ones.
// - published-address reply: index 000011, argument, CRC7, end bit one.
// - published relative address sits in upper 16 argument bits.
// - interface reply echoes voltage code in 19:16, pattern in 15:8.
// - interface reply only if voltage accepted; index 001000, 39:20 zero.
// - voltage code 0001b is 2.7-3.6 V; others not accepted here.
// - status query with index 001101 returns task status when argument bit 15 set.
// - unused reserved status bits always read as zero.
// - bits 23 and 22 clear after next valid command, one command later.
// - execution flags latch until a full status reply ends, even one built before they were set; clear-by-read bits clear after send.
// - bit 25 follows the current lock state continuously.
// - bit 31 set on argument argument_range_fault; cleared by read.
// - bit 30 set on address misaligned with block length.
// - bit 29 set on bad block length or byte count; cleared by read.
// - bit 28 erase order fault, bit 27 erase selection fault; read-cleared.
// - bit 26 set on write to protected block or card; read-cleared.
// - bit 24 set on lock or unlock failure; cleared by read.
// - bit 23 previous command checksum fault, bit 22 illegal command.
// - bits 21, 20, 19: ecc, controller, general fault; read-cleared.
// - bit 16 set on card-specific data overwrite fault; read-cleared.
// - bit 15 set when erase skipped protected blocks; read-cleared.
// - bits 12:9 hold current card state number 1 to 8.
module crsu_core
    import crsu_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic link_clk_i,
    input wire logic req_valid_i,
    input crsu_req_s req_i,
    output logic req_ready_o,
    input wire logic cmd_valid_i,
    input wire logic cmd_crc_bad_i,
    input wire logic cmd_illegal_i,
    input crsu_events_s events_i,
    input wire logic locked_flag_i,
    input wire logic [3:0] card_state_i,
    input wire logic [31:0] operating_condition_reg_i,
    input wire logic [15:0] relative_card_address_i,
    input wire logic [31:0] task_status_i,
    input wire logic [12:0] low_status_i,
    output logic [31:0] card_status_word_o,
    output logic cmd_line_o,
    output logic cmd_oe_n_o,
    output logic busy_o
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [6:0] crc7(input logic [39:0] bits);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = 39; i >= 0; i--)
        begin
            fb = bits[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
        end
        return c;
    endfunction

    // ************************************************************
    // status word
    // ************************************************************
    logic [31:0] sticky;
    logic crc_pend;
    logic illegal_pend;
    logic sent_ack;
    logic [31:0] sent_mask;
    logic [31:0] ev_vec;
    logic [31:0] status_view;

    always_comb
    begin
        ev_vec = 32'h00000000;
        ev_vec[ST_RANGE] = events_i.argument_range_fault;
        ev_vec[ST_ADDR] = events_i.address_fault;
        ev_vec[ST_BLKLEN] = events_i.block_length_fault;
        ev_vec[ST_ERSEQ] = events_i.erase_order_fault;
        ev_vec[ST_ERSEL] = events_i.erase_selection_fault;
        ev_vec[ST_PROT] = events_i.protected_write_fault;
        ev_vec[ST_LOCKFAIL] = events_i.lock_fault;
        ev_vec[ST_ECC] = events_i.ecc_fault;
        ev_vec[ST_CTRL] = events_i.controller_fault;
        ev_vec[ST_GENERAL] = events_i.general_fault;
        ev_vec[ST_SPECDATA] = events_i.specific_data_write_fault;
        ev_vec[ST_ERASESKIP] = events_i.erase_skip;
    end

    // set wins over clear-by-read in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            sticky <= STATUS_RESET;
        else if (ce_i)
            sticky <= (sticky & ~(sent_ack ? sent_mask : 32'h00000000))
                | ev_vec;
    end

    // previous-command flags: shown in the reply to the next command,
    // then dropped when a further valid command arrives
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            crc_pend <= 1'b0;
            illegal_pend <= 1'b0;
        end
        else if (ce_i)
        begin
            if (cmd_crc_bad_i)
                crc_pend <= 1'b1;
            else if (cmd_valid_i)
                crc_pend <= 1'b0;
            if (cmd_illegal_i)
                illegal_pend <= 1'b1;
            else if (cmd_valid_i)
                illegal_pend <= 1'b0;
        end
    end

    always_comb
    begin
        status_view = sticky & CLEAR_ON_READ;
        status_view[ST_LOCKED] = locked_flag_i;
        status_view[ST_CRC] = crc_pend;
        status_view[ST_ILLEGAL] = illegal_pend;
        status_view[ST_STATE_LO +: 4] = card_state_i;
        status_view[8:0] = low_status_i[8:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            card_status_word_o <= STATUS_RESET;
        else if (ce_i)
            card_status_word_o <= status_view;
    end

    // ************************************************************
    // frame build
    // ************************************************************
    logic [39:0] head;
    logic [47:0] next_frame;
    logic accept;
    logic [47:0] frame;
    logic launch_tgl;
    logic done_s1;
    logic done_s2;
    logic done_s3;
    logic in_flight;
    logic link_done_tgl;

    always_comb
    begin
        head = 40'h0000000000;
        accept = 1'b1;
        case (req_i.kind)
            CRSU_KIND_OPCOND:
                head = {2'b00, IDX_ALL_ONES, operating_condition_reg_i};
            CRSU_KIND_PUBLISH:
                head = {2'b00, IDX_PUBLISH, relative_card_address_i,
                    status_view[ST_CRC], status_view[ST_ILLEGAL],
                    status_view[ST_GENERAL], status_view[12:0]};
            CRSU_KIND_IFCOND:
            begin
                head = {2'b00, IDX_IFCOND, IFCOND_RESVD,
                    req_i.arg[19:16], req_i.arg[15:8]};
                // only the 2.7-3.6 V range is accepted
                accept = (req_i.arg[19:16] == VOLT_HIGH);
            end
            CRSU_KIND_STATUS:
                head = {2'b00, req_i.index,
                    req_i.arg[QUERY_SEL_BIT] && req_i.index == 6'h0D
                    ? task_status_i : status_view};
            default:
                head = 40'h0000000000;
        endcase
        if (req_i.kind == CRSU_KIND_OPCOND)
            next_frame = {head, OPCOND_TRAILER, 1'b1};
        else
            next_frame = {head, crc7(head), 1'b1};
    end

    assign req_ready_o = !in_flight;
    assign busy_o = in_flight;

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            frame <= 48'h000000000000;
            launch_tgl <= 1'b0;
            in_flight <= 1'b0;
            sent_ack <= 1'b0;
            sent_mask <= 32'h00000000;
            done_s3 <= 1'b0;
        end
        else if (ce_i)
        begin
            done_s3 <= done_s2;
            sent_ack <= 1'b0;
            if (in_flight && (done_s2 != done_s3))
            begin
                in_flight <= 1'b0;
                sent_ack <= 1'b1;
            end
            else if (req_valid_i && !in_flight && accept)
            begin
                frame <= next_frame;
                launch_tgl <= !launch_tgl;
                in_flight <= 1'b1;
                // only frames carrying the full word clear read flags
                sent_mask <= (req_i.kind == CRSU_KIND_STATUS &&
                    !(req_i.arg[QUERY_SEL_BIT] && req_i.index == 6'h0D))
                    ? CLEAR_ON_READ : 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
        end
        else if (ce_i)
        begin
            done_s1 <= link_done_tgl;
            done_s2 <= done_s1;
        end
    end

    // ************************************************************
    // link side shifter (bus clock)
    // ************************************************************
    logic link_tgl_s1;
    logic link_tgl_s2;
    logic link_tgl_seen;
    logic link_tail;
    logic [5:0] bit_cnt;
    logic [47:0] shreg;
    logic shifting;

    // frame word is stable while in_flight, so it is sampled directly
    // once the launch toggle has crossed
    always_ff @(posedge link_clk_i)
    begin
        link_tgl_s1 <= launch_tgl;
        link_tgl_s2 <= link_tgl_s1;
    end

    always_ff @(posedge link_clk_i)
    begin
        if (!rstn_i)
        begin
            link_tgl_seen <= 1'b0;
            link_done_tgl <= 1'b0;
            link_tail <= 1'b0;
            bit_cnt <= 6'h00;
            shreg <= 48'hFFFFFFFFFFFF;
            shifting <= 1'b0;
        end
        else if (link_tail)
        begin
            // done only once the line is released, so the host may
            // stop the bus clock without leaving the pin driven
            link_tail <= 1'b0;
            link_done_tgl <= !link_done_tgl;
        end
        else if (!shifting && (link_tgl_s2 != link_tgl_seen))
        begin
            link_tgl_seen <= link_tgl_s2;
            shreg <= frame;
            bit_cnt <= 6'h2F;
            shifting <= 1'b1;
        end
        else if (shifting)
        begin
            shreg <= {shreg[46:0], 1'b1};
            if (bit_cnt == 6'h00)
            begin
                shifting <= 1'b0;
                link_tail <= 1'b1;
            end
            else
                bit_cnt <= bit_cnt - 6'h01;
        end
    end

    always_ff @(posedge link_clk_i)
    begin
        if (!rstn_i)
        begin
            cmd_line_o <= 1'b1;
            cmd_oe_n_o <= 1'b1;
        end
        else
        begin
            cmd_line_o <= shifting ? shreg[47] : 1'b1;
            cmd_oe_n_o <= !shifting;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_LOCK_TRACK: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i |=> card_status_word_o[ST_LOCKED] == $past(locked_flag_i))
        else $error("lock bit does not follow lock state");

    AST_RESVD_ZERO: assert property (@(posedge clk_i) disable iff (!rstn_i)
        card_status_word_o[18:17] == 2'b00)
        else $error("reserved status bits not zero");

    AST_RANGE_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && events_i.argument_range_fault |=> sticky[ST_RANGE])
        else $error("range fault not latched");

    AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && sent_ack && events_i.general_fault |=> sticky[ST_GENERAL])
        else $error("event lost against read clear");

    AST_CRC_PREV: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && cmd_crc_bad_i |=> crc_pend)
        else $error("checksum fault not recorded");

    AST_PREV_CLEAR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && cmd_valid_i && !cmd_illegal_i |=> !illegal_pend)
        else $error("illegal flag not cleared by valid command");

    AST_IFCOND_REJECT: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && req_valid_i && !in_flight && req_i.kind == CRSU_KIND_IFCOND
        && req_i.arg[19:16] != VOLT_HIGH |=> !in_flight)
        else $error("interface reply sent for rejected voltage");

    AST_OPCOND_TRAIL: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && req_valid_i && !in_flight && req_i.kind == CRSU_KIND_OPCOND
        |=> frame[7:0] == 8'hFF && frame[45:40] == IDX_ALL_ONES)
        else $error("operating-condition frame trailer wrong");

    AST_STATE_FIELD: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i |=> card_status_word_o[12:9] == $past(card_state_i))
        else $error("state field does not follow card state");

    AST_READ_CLEAR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && sent_ack && sent_mask[ST_RANGE]
        && !events_i.argument_range_fault |=> !sticky[ST_RANGE])
        else $error("range flag not cleared after status sent");

    AST_PUBLISH_IDX: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && req_valid_i && !in_flight && req_i.kind == CRSU_KIND_PUBLISH
        |=> frame[45:40] == IDX_PUBLISH && frame[0])
        else $error("published-address frame index or end bit wrong");

endmodule

// >>> crsu_host_model.sv
/* crsu_host_model: host end of the command line; gates the bus clock
   and gathers 48-bit response frames.
   assumes: card drives cmd_line while oe_n is low, MSB first. */
`timescale 1ns/1ps
module crsu_host_model
(
    input wire logic run_i,
    input wire logic cmd_line_i,
    input wire logic cmd_oe_n_i,
    output logic link_clk_o,
    output logic [47:0] frame_o,
    output int frame_cnt_o
);
    logic [47:0] shift;
    int bits;

    // ************************************************************
    // bus clock, still between frames
    // ************************************************************
    initial
    begin
        link_clk_o = 1'b0;
        shift = '0;
        bits = 0;
        frame_o = '0;
        frame_cnt_o = 0;
        #3.3;
        forever
        begin
            #62.5;
            if (run_i || link_clk_o)
                link_clk_o = ~link_clk_o;
        end
    end

    // ************************************************************
    // frame capture
    // ************************************************************
    // sample mid-bit so the card's launch edge never races
    always @(negedge link_clk_o)
    begin
        if (cmd_oe_n_i === 1'b0)
        begin
            shift = {shift[46:0], cmd_line_i};
            bits++;
            if (bits == 48)
            begin
                frame_o = shift;
                frame_cnt_o++;
                bits = 0;
            end
        end
        else
            bits = 0;
    end
endmodule

// >>> crsu_core_tb.sv
/* crsu_core_tb: self-checking bench for crsu_core.
   assumes: crsu_pkg and crsu_host_model compiled first. */
`timescale 1ns/1ps
module crsu_core_tb;
    import crsu_pkg::*;
    logic clk, rstn, ce, req_valid, cmd_valid, crc_bad, illegal, locked;
    crsu_req_s req;
    crsu_events_s ev;
    logic [3:0] state;
    logic [31:0] operating_condition_reg, task_st, word;
    logic [15:0] relative_card_address;
    logic ready, busy, line, oe_n, lclk;
    logic [47:0] frame;
    int nfr, error_cnt, cmp_count;
    localparam logic [31:0] BASE = 32'h02000600;
    int pos [12] = '{31, 30, 29, 28, 27, 26, 24, 21, 20, 19, 16, 15};

    crsu_core i_dut (.clk_i(clk), .rstn_i(rstn), .ce_i(ce),
        .link_clk_i(lclk), .req_valid_i(req_valid), .req_i(req),
        .req_ready_o(ready), .cmd_valid_i(cmd_valid),
        .cmd_crc_bad_i(crc_bad), .cmd_illegal_i(illegal), .events_i(ev),
        .locked_flag_i(locked), .card_state_i(state),
        .operating_condition_reg_i(operating_condition_reg), .relative_card_address_i(relative_card_address),
        .task_status_i(task_st), .low_status_i({4'h3, 9'h000}),
        .card_status_word_o(word), .cmd_line_o(line),
        .cmd_oe_n_o(oe_n), .busy_o(busy));

    crsu_host_model i_host (.run_i(busy | ~rstn), .cmd_line_i(line),
        .cmd_oe_n_i(oe_n), .link_clk_o(lclk), .frame_o(frame),
        .frame_cnt_o(nfr));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic report_and_stop();
        $display("Comparisons %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk_w(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_f(logic [47:0] e);
        cmp_count++;
        if (frame !== e)
        begin
            error_cnt++;
            $display("Error frame expected %h seen %h", e, frame);
        end
    endtask

    function automatic logic [47:0] mk(logic [5:0] ix, logic [31:0] b);
        logic [47:0] f;
        logic [6:0] c;
        logic fb;
        f = {2'b00, ix, b, 8'h01};
        c = 7'h00;
        for (int i = 47; i >= 8; i--)
        begin
            fb = f[i] ^ c[6];
            c = {c[5:0], 1'b0};
            if (fb)
                c = c ^ 7'h09;
        end
        f[7:1] = c;
        return f;
    endfunction

    // frame wait is bounded: 48 link bits are about 1500 clocks
    task automatic send(crsu_kind_e k, logic [5:0] ix, logic [31:0] a);
        int n;
        n = nfr;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{k, ix, a};
        @(posedge clk);
        req_valid <= 1'b0;
        for (int t = 0; t < 4000 && nfr == n; t++) @(posedge clk);
        for (int t = 0; t < 100 && ready !== 1'b1; t++) @(posedge clk);
        repeat (3) @(negedge clk);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_flags();
        @(posedge clk);
        crc_bad <= 1'b1;
        illegal <= 1'b1;
        @(posedge clk);
        crc_bad <= 1'b0;
        illegal <= 1'b0;
        repeat (3) @(negedge clk);
        chk_w("word", BASE | 32'h00C00000, word);
        send(CRSU_KIND_PUBLISH, 6'h03, 32'h0);
        chk_f(mk(6'h03, {relative_card_address, 3'b110, 4'h3, 9'h000}));
        chk_w("word", BASE | 32'h00C00000, word);
        @(posedge clk);
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        repeat (3) @(negedge clk);
        chk_w("word", BASE, word);
    endtask

    task automatic t_ifcond();
        int n;
        logic [3:0] bad [5] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'hF};
        send(CRSU_KIND_IFCOND, 6'h08, 32'h000001A5 << 8);
        chk_f(mk(6'h08, {20'h0, 4'h1, 8'hA5}));
        for (int i = 0; i < 5; i++)
        begin
            n = nfr;
            @(posedge clk);
            req_valid <= 1'b1;
            req <= '{CRSU_KIND_IFCOND, 6'h08, {12'h0, bad[i], 16'h5A00}};
            @(posedge clk);
            req_valid <= 1'b0;
            repeat (600) @(negedge clk);
            chk_w("frames", 32'(n), 32'(nfr));
            chk_w("ready", 32'h1, {31'h0, ready});
        end
    endtask

    task automatic t_query();
        send(CRSU_KIND_STATUS, 6'd13, 32'h00008000);
        chk_f(mk(6'd13, task_st));
        send(CRSU_KIND_STATUS, 6'd13, 32'h0);
        chk_f(mk(6'd13, BASE));
        send(CRSU_KIND_STATUS, 6'd7, 32'h00008000);
        chk_f(mk(6'd7, BASE));
        @(posedge clk);
        locked <= 1'b0;
        repeat (3) @(negedge clk);
        chk_w("word", 32'h00000600, word);
        @(posedge clk);
        locked <= 1'b1;
    endtask

    task automatic t_events();
        logic [31:0] e;
        for (int i = 0; i <= 12; i++)
        begin
            // last pass raises every flag together
            e = (i == 12) ? BASE | 32'hFD398000 : BASE | (32'h1 << pos[i]);
            @(posedge clk);
            ev <= (i == 12) ? '1 : crsu_events_s'(12'h800 >> i);
            @(posedge clk);
            ev <= '0;
            repeat (3) @(negedge clk);
            chk_w("word", e, word);
            send(CRSU_KIND_STATUS, 6'd13, 32'h0);
            chk_f(mk(6'd13, e));
            chk_w("word", BASE, word);
        end
        // event held across the read-clear cycle: set must win
        @(posedge clk);
        ev.general_fault <= 1'b1;
        send(CRSU_KIND_STATUS, 6'd13, 32'h0);
        ev.general_fault <= 1'b0;
        chk_f(mk(6'd13, BASE | 32'h00080000));
        repeat (3) @(negedge clk);
        chk_w("word", BASE | 32'h00080000, word);
        // clock enable low: an event pulse must not be taken
        @(posedge clk);
        ce <= 1'b0;
        ev.argument_range_fault <= 1'b1;
        @(posedge clk);
        ev.argument_range_fault <= 1'b0;
        ce <= 1'b1;
        repeat (3) @(negedge clk);
        chk_w("word", BASE | 32'h00080000, word);
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial
    begin
        rstn = 1'b0;
        ce = 1'b1;
        req_valid = 1'b0;
        cmd_valid = 1'b0;
        crc_bad = 1'b0;
        illegal = 1'b0;
        locked = 1'b1;
        req = '0;
        ev = '0;
        state = 4'h3;
        operating_condition_reg = 32'h80FF8000;
        task_st = 32'h13579BDF;
        relative_card_address = 16'hB2C4;
        error_cnt = 0;
        cmp_count = 0;
        // long reset so the link clock, kept running by ~rstn, sees three rising edges
        repeat (80) @(posedge clk);
        @(negedge clk);
        chk_w("reset word", 32'h0, word);
        chk_w("reset pins", 32'h7, {29'h0, line, oe_n, ready});
        @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(negedge clk);
        send(CRSU_KIND_OPCOND, 6'h3F, 32'h0);
        chk_f({2'b00, 6'h3F, operating_condition_reg, 7'h7F, 1'b1});
        t_flags();
        t_ifcond();
        t_query();
        t_events();
        report_and_stop();
    end

    initial
    begin
        #300000;
        error_cnt++;
        report_and_stop();
    end
endmodule
